// [ptc_pkg.sv]
// Purpose: Constants, register map and state types for the pin change edge detector.
// Assumes: 32-bit AXI4-Lite slave, 8-bit registers in the low byte of aligned words.
// Notes:   Ports A and B are eight pins wide, port C lacks pin 5; port E carries only pin 3.
// How it works
// R1 - Port E pin 3 falling edge enable works
// R2 - Each enabled edge sets pin and summary
// R3 - Port E flag on enabled rise or fall
// R4 - Both enables clear means no flag
// R5 - Flags stay set until software clears
// R6 - Hardware set wins over software write
// R7 - Port E only bit 3; others zero
// R8 - Reset pin or LOW_VOLTAGE_PROGRAM_ENABLE blocks pin 3
// R9 - Every reset clears enables and flags
// R10 - Ports A, B, C work per pin alike
// R11 - Sync pins; interrupt needs four enables
`default_nettype none
package ptc_pkg;

   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NPORT  = 4;
   localparam int PW     = 8;

   // Register word indices; the byte address is four times the index.
   localparam logic [5:0] IDX_GCTRL     = 6'h00;
   localparam logic [5:0] IDX_PERIPHERAL_IRQ_ENABLE_0      = 6'h01;
   localparam logic [5:0] IDX_PORT_BASE = 6'h02;
   localparam int         PORT_STRIDE   = 3;
   localparam int         OFS_RISE      = 0;
   localparam int         OFS_FALL      = 1;
   localparam int         OFS_FLAG      = 2;
   localparam logic [5:0] IDX_ISTAT     = 6'h0E;
   localparam logic [5:0] IDX_IMASK     = 6'h0F;
   localparam logic [5:0] IDX_PINCFG    = 6'h10;
   localparam logic [5:0] IDX_SUMMARY   = 6'h11;

   // Field positions.
   localparam int BIT_GIE     = 7;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE    = 6;
   localparam int BIT_CHANGE_IRQ_ENABLE   = 4;
   localparam int BIT_EXT_RST = 0;
   localparam int BIT_LVP     = 1;
   localparam int BIT_EVENT   = 0;
   localparam int BIT_SUMMARY = 0;

   // Implemented pins per port: A, B, C (bit 5 absent), E (bit 3 only).
   localparam int PORT_E = 3;
   localparam int E_PIN  = 3;
   localparam logic [NPORT-1:0][PW-1:0] PORT_IMPL = {8'h08, 8'hDF, 8'hFF, 8'hFF};

   // Settling time before edges count after reset.
   localparam logic [1:0] PRIME_DONE = 2'h3;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WS_COLLECT = 2'b01,
      WS_RESP    = 2'b10
   } ptc_wstate_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,
      RS_DATA = 2'b10
   } ptc_rstate_t;

endpackage : ptc_pkg
`default_nettype wire

// [ptc_sync.sv]
// Purpose: Two-flop synchroniser for the port pins.
// Assumes: Inputs are asynchronous board levels.
// Notes:   The first stage feeds only the second stage.
`default_nettype none
`timescale 1ns/100ps
module ptc_sync
   import ptc_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_clk_en,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ptc_sync_st_t;

   ptc_sync_st_t q_reg;
   ptc_sync_st_t q_next;

   // Shift the pin levels one stage per enabled clock.
   always_comb begin
      q_next = q_reg;
      if (i_clk_en) begin
         q_next.s1 = i_async;
         q_next.s2 = q_reg.s1;
      end
   end

   // State register, cleared by reset.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign o_sync = q_reg.s2;

endmodule : ptc_sync
`default_nettype wire

// [ptc_pin_change.sv]
// Purpose: Per-pin rising/falling edge detector with sticky flags and interrupt.
// Assumes: Single 20 MHz clock; AXI4-Lite register access; pins asynchronous.
// Notes:   Edges count three enabled clocks after reset, once the pins settle.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
`timescale 1ns/100ps
module ptc_pin_change
   import ptc_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clk_en,
   input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_awvalid,
   output logic                   o_s_axi_awready,
   input  wire logic [DATA_W-1:0] i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   input  wire logic              i_s_axi_wvalid,
   output logic                   o_s_axi_wready,
   output logic [1:0]             o_s_axi_bresp,
   output logic                   o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic              i_s_axi_arvalid,
   output logic                   o_s_axi_arready,
   output logic [DATA_W-1:0]      o_s_axi_rdata,
   output logic [1:0]             o_s_axi_rresp,
   output logic                   o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   input  wire logic [PW-1:0]     i_porta,
   input  wire logic [PW-1:0]     i_portb,
   input  wire logic [PW-1:0]     i_portc,
   input  wire logic              i_porte_pin3,
   output logic                   o_irq,
   output logic                   o_change_summary
);

   typedef struct packed {
      ptc_wstate_t                ws;
      logic                       aw_got;
      logic [5:0]                 aw_idx;
      logic                       w_got;
      logic [PW-1:0]              w_byte;
      logic                       w_lane0;
      logic                       awready;
      logic                       wready;
      logic                       bvalid;
      logic [1:0]                 bresp;
      ptc_rstate_t                rs;
      logic                       arready;
      logic                       rvalid;
      logic [1:0]                 rresp;
      logic [PW-1:0]              rbyte;
      logic                       global_irq_enable;
      logic                       peripheral_irq_enable;
      logic                       ioc_ie;
      logic                       ext_rst_en;
      logic                       lvp_en;
      logic [NPORT-1:0][PW-1:0]   rise;
      logic [NPORT-1:0][PW-1:0]   fall;
      logic [NPORT-1:0][PW-1:0]   flag;
      logic [NPORT-1:0][PW-1:0]   prev;
      logic [1:0]                 prime;
      logic                       istat;
      logic                       imask;
      logic                       irq;
      logic                       summary;
   } ptc_state_t;

   ptc_state_t q_reg;
   ptc_state_t q_next;

   logic [NPORT-1:0][PW-1:0] pins_s;
   logic [NPORT-1:0][PW-1:0] impl;
   logic [NPORT-1:0][PW-1:0] rise_hit;
   logic [NPORT-1:0][PW-1:0] fall_hit;
   logic [NPORT-1:0][PW-1:0] hit;
   logic                     wr_en;
   logic                     wr_hit;
   logic                     rd_hit;
   logic [PW-1:0]            rd_byte;
   logic [5:0]               rd_idx;
   logic [5:0]               pidx;
   logic [5:0]               rpidx;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   // R11 pins synchronised first
   ptc_sync #(
      .W (NPORT*PW)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .i_async    ({4'h0, i_porte_pin3, 3'h0, i_portc, i_portb, i_porta}),
      .o_sync     (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection.

   // Find enabled edges per pin against the previous sample.
   always_comb begin
      impl = PORT_IMPL;
      // R8 reset pin blocks
      if (q_reg.ext_rst_en || q_reg.lvp_en) begin
         impl[PORT_E][E_PIN] = 1'b0;
      end
      for (int p = 0; p < NPORT; p++) begin
         // R1 falling edge enable
         fall_hit[p] = ~pins_s[p] & q_reg.prev[p] & q_reg.fall[p] & impl[p];
         // R10 per pin alike
         rise_hit[p] = pins_s[p] & ~q_reg.prev[p] & q_reg.rise[p] & impl[p];
         // R4 no enable, none
         if (q_reg.prime != PRIME_DONE) begin
            fall_hit[p] = '0;
            rise_hit[p] = '0;
         end
      end
      // R3 rise or fall
      hit = rise_hit | fall_hit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode.

   // Select the register byte addressed by the read channel.
   always_comb begin
      rd_idx  = i_s_axi_araddr[7:2];
      rd_hit  = 1'b1;
      rd_byte = '0;
      case (rd_idx)
         IDX_GCTRL: begin
            rd_byte[BIT_GIE]  = q_reg.global_irq_enable;
            rd_byte[BIT_PERIPHERAL_IRQ_ENABLE] = q_reg.peripheral_irq_enable;
         end
         IDX_PERIPHERAL_IRQ_ENABLE_0:    rd_byte[BIT_CHANGE_IRQ_ENABLE] = q_reg.ioc_ie;
         IDX_ISTAT:   rd_byte[BIT_EVENT] = q_reg.istat;
         IDX_IMASK:   rd_byte[BIT_EVENT] = q_reg.imask;
         IDX_PINCFG: begin
            rd_byte[BIT_EXT_RST] = q_reg.ext_rst_en;
            rd_byte[BIT_LVP]     = q_reg.lvp_en;
         end
         IDX_SUMMARY: rd_byte[BIT_SUMMARY] = q_reg.summary;
         default:     rd_hit = 1'b0;
      endcase
      for (int p = 0; p < NPORT; p++) begin
         rpidx = IDX_PORT_BASE + 6'(PORT_STRIDE * p);
         // R7 unused bits zero
         if (rd_idx == rpidx + 6'(OFS_RISE)) begin
            rd_byte = q_reg.rise[p];
            rd_hit  = 1'b1;
         end
         if (rd_idx == rpidx + 6'(OFS_FALL)) begin
            rd_byte = q_reg.fall[p];
            rd_hit  = 1'b1;
         end
         if (rd_idx == rpidx + 6'(OFS_FLAG)) begin
            rd_byte = q_reg.flag[p];
            rd_hit  = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Bus handshakes, register writes, flag setting and interrupt.
   always_comb begin
      q_next = q_reg;
      wr_en  = (q_reg.ws == WS_COLLECT) && q_reg.aw_got && q_reg.w_got;
      wr_hit = 1'b0;
      if (i_clk_en) begin
         // Collect address and data in either order.
         if (i_s_axi_awvalid && q_reg.awready) begin
            q_next.aw_got = 1'b1;
            q_next.aw_idx = i_s_axi_awaddr[7:2];
         end
         if (i_s_axi_wvalid && q_reg.wready) begin
            q_next.w_got   = 1'b1;
            q_next.w_byte  = i_s_axi_wdata[PW-1:0];
            q_next.w_lane0 = i_s_axi_wstrb[0];
         end
         if (q_reg.prime != PRIME_DONE) begin
            q_next.prime = q_reg.prime + 2'h1;
         end
         q_next.prev = pins_s;
         if (wr_en) begin
            q_next.aw_got = 1'b0;
            q_next.w_got  = 1'b0;
            q_next.ws     = WS_RESP;
            q_next.bvalid = 1'b1;
            wr_hit        = 1'b1;
            case (q_reg.aw_idx)
               IDX_GCTRL: begin
                  if (q_reg.w_lane0) begin
                     q_next.global_irq_enable  = q_reg.w_byte[BIT_GIE];
                     q_next.peripheral_irq_enable = q_reg.w_byte[BIT_PERIPHERAL_IRQ_ENABLE];
                  end
               end
               IDX_PERIPHERAL_IRQ_ENABLE_0: begin
                  if (q_reg.w_lane0) begin
                     q_next.ioc_ie = q_reg.w_byte[BIT_CHANGE_IRQ_ENABLE];
                  end
               end
               IDX_ISTAT: begin
                  if (q_reg.w_lane0 && q_reg.w_byte[BIT_EVENT]) begin
                     q_next.istat = 1'b0;
                  end
               end
               IDX_IMASK: begin
                  if (q_reg.w_lane0) begin
                     q_next.imask = q_reg.w_byte[BIT_EVENT];
                  end
               end
               IDX_PINCFG: begin
                  if (q_reg.w_lane0) begin
                     q_next.ext_rst_en = q_reg.w_byte[BIT_EXT_RST];
                     q_next.lvp_en     = q_reg.w_byte[BIT_LVP];
                  end
               end
               IDX_SUMMARY: begin
               end
               default: wr_hit = 1'b0;
            endcase
            for (int p = 0; p < NPORT; p++) begin
               pidx = IDX_PORT_BASE + 6'(PORT_STRIDE * p);
               // R7 writes masked
               if (q_reg.aw_idx == pidx + 6'(OFS_RISE)) begin
                  wr_hit = 1'b1;
                  if (q_reg.w_lane0) begin
                     q_next.rise[p] = q_reg.w_byte & PORT_IMPL[p];
                  end
               end
               if (q_reg.aw_idx == pidx + 6'(OFS_FALL)) begin
                  wr_hit = 1'b1;
                  if (q_reg.w_lane0) begin
                     q_next.fall[p] = q_reg.w_byte & PORT_IMPL[p];
                  end
               end
               // R5 software clears flags
               if (q_reg.aw_idx == pidx + 6'(OFS_FLAG)) begin
                  wr_hit = 1'b1;
                  if (q_reg.w_lane0) begin
                     q_next.flag[p] = q_reg.w_byte & PORT_IMPL[p];
                  end
               end
            end
            q_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if ((q_reg.ws == WS_RESP) && i_s_axi_bready) begin
            q_next.bvalid = 1'b0;
            q_next.ws     = WS_COLLECT;
         end
         // Read channel: answer one cycle after the address is taken.
         case (q_reg.rs)
            RS_IDLE: begin
               if (i_s_axi_arvalid && q_reg.arready) begin
                  q_next.rs     = RS_DATA;
                  q_next.rvalid = 1'b1;
                  q_next.rbyte  = rd_byte;
                  q_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
               end
            end
            RS_DATA: begin
               if (i_s_axi_rready) begin
                  q_next.rs     = RS_IDLE;
                  q_next.rvalid = 1'b0;
               end
            end
            default: q_next.rs = RS_IDLE;
         endcase
         // R6 hardware set wins
         for (int p = 0; p < NPORT; p++) begin
            q_next.flag[p] = q_next.flag[p] | hit[p];
         end
         // R2 summary and event
         if (|hit) begin
            q_next.istat = 1'b1;
         end
         q_next.summary = |q_next.flag;
         // R11 four enables gate
         q_next.irq = q_next.istat && q_next.imask && q_next.ioc_ie
                      && q_next.peripheral_irq_enable && q_next.global_irq_enable;
         q_next.awready = (q_next.ws == WS_COLLECT) && !q_next.aw_got;
         q_next.wready  = (q_next.ws == WS_COLLECT) && !q_next.w_got;
         q_next.arready = (q_next.rs == RS_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   // R9 all reset clear
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q_reg    <= '0;
         q_reg.ws <= WS_COLLECT;
         q_reg.rs <= RS_IDLE;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs come straight from the state register.
   assign o_s_axi_awready  = q_reg.awready;
   assign o_s_axi_wready   = q_reg.wready;
   assign o_s_axi_bvalid   = q_reg.bvalid;
   assign o_s_axi_bresp    = q_reg.bresp;
   assign o_s_axi_arready  = q_reg.arready;
   assign o_s_axi_rvalid   = q_reg.rvalid;
   assign o_s_axi_rresp    = q_reg.rresp;
   assign o_s_axi_rdata    = {24'h000000, q_reg.rbyte};
   assign o_irq            = q_reg.irq;
   assign o_change_summary = q_reg.summary;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   AST_FALL_E3: assert property (@(posedge i_core_clk) disable iff (i_rst) // R1
      i_clk_en && fall_hit[PORT_E][E_PIN] |=> q_reg.flag[PORT_E][E_PIN] && o_change_summary)
      else $error("Port E pin 3 falling edge did not set its flag.");

   AST_EVENT_SUMMARY: assert property (@(posedge i_core_clk) disable iff (i_rst) // R2
      i_clk_en && (|hit) |=> q_reg.istat && o_change_summary)
      else $error("Enabled edge did not set the summary flag.");

   AST_RISE_E3: assert property (@(posedge i_core_clk) disable iff (i_rst) // R3
      i_clk_en && pins_s[PORT_E][E_PIN] && !q_reg.prev[PORT_E][E_PIN]
      && q_reg.rise[PORT_E][E_PIN] && !q_reg.ext_rst_en && !q_reg.lvp_en
      && q_reg.prime == PRIME_DONE |=> q_reg.flag[PORT_E][E_PIN])
      else $error("Port E pin 3 rising edge did not set its flag.");

   AST_NO_ENABLE: assert property (@(posedge i_core_clk) disable iff (i_rst) // R4
      i_clk_en && !q_reg.rise[PORT_E][E_PIN] && !q_reg.fall[PORT_E][E_PIN]
      && !q_reg.flag[PORT_E][E_PIN] && !wr_en |=> !q_reg.flag[PORT_E][E_PIN])
      else $error("Port E pin 3 flag set with both enables clear.");

   AST_FLAG_STICKY: assert property (@(posedge i_core_clk) disable iff (i_rst) // R5
      i_clk_en && q_reg.flag[0][0] && !wr_en |=> q_reg.flag[0][0] [*1] ##1 1'b1)
      else $error("Port A pin 0 flag dropped without a write.");

   AST_SET_WINS: assert property (@(posedge i_core_clk) disable iff (i_rst) // R6
      i_clk_en && wr_en && hit[1][2] |=> q_reg.flag[1][2])
      else $error("Edge lost against a simultaneous register write.");

   AST_UNUSED_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst) // R7
      ((q_reg.rise[PORT_E] | q_reg.fall[PORT_E] | q_reg.flag[PORT_E])
       & ~PORT_IMPL[PORT_E]) == '0 && o_s_axi_rdata[DATA_W-1:PW] == '0)
      else $error("Unimplemented port E bit or upper data bit is nonzero.");

   AST_BLOCKED_E3: assert property (@(posedge i_core_clk) disable iff (i_rst) // R8
      (q_reg.ext_rst_en || q_reg.lvp_en) |-> !hit[PORT_E][E_PIN])
      else $error("Edge detected on port E pin 3 while blocked.");

   AST_RESET_CLEAR: assert property (@(posedge i_core_clk) // R9
      $past(i_rst) |-> q_reg.flag == '0 && q_reg.rise == '0 && q_reg.fall == '0)
      else $error("Enables or flags not clear after reset.");

   AST_PORT_A_RISE: assert property (@(posedge i_core_clk) disable iff (i_rst) // R10
      i_clk_en && rise_hit[0][5] ##1 !wr_en |=> q_reg.flag[0][5])
      else $error("Port A pin 5 rising edge did not hold its flag.");

   AST_IRQ_GATES: assert property (@(posedge i_core_clk) disable iff (i_rst) // R11
      o_irq |-> q_reg.global_irq_enable && q_reg.peripheral_irq_enable && q_reg.ioc_ie && q_reg.istat && q_reg.imask)
      else $error("Interrupt raised without all enables.");

endmodule : ptc_pin_change
`default_nettype wire

// [ptc_pin_model.sv]
// Purpose: Board model that drives the port pins of the change detector.
// Assumes: Levels change just after a rising clock edge.
// Notes:   Pins are plain board levels; nothing here is open-drain.
`default_nettype none
`timescale 1ns/100ps
module ptc_pin_model
   import ptc_pkg::*;
(
   input  wire logic       i_core_clk,
   output var  logic [7:0] o_porta,
   output var  logic [7:0] o_portb,
   output var  logic [7:0] o_portc,
   output var  logic       o_porte_pin3
);
   // All pins start low so that no edge is seen at power-up.
   initial begin
      o_porta = 8'h00;
      o_portb = 8'h00;
      o_portc = 8'h00;
      o_porte_pin3 = 1'b0;
   end

   // Sets one port's levels just after the next rising edge.
   task automatic drive(input int p, input logic [7:0] v);
      @(posedge i_core_clk);
      case (p)
         0: o_porta <= v;
         1: o_portb <= v;
         2: o_portc <= v;
         default: o_porte_pin3 <= v[E_PIN];
      endcase
   endtask : drive
endmodule : ptc_pin_model
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the pin change detector.
// Assumes: AXI4-Lite master in the bench; board pins from the pin model.
// Notes:   Waits of eight cycles cover the synchroniser and edge latency.
`default_nettype none
`timescale 1ns/100ps
module tb
   import ptc_pkg::*;
;
   logic        clk, rst, awvalid, wvalid, arvalid, bready, rready, clk_en;
   logic [7:0]  awaddr, araddr, pa_w, pb_w, pc_w;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid, irq, summ, pe_w;
   logic [1:0]  bresp, rresp, r;
   int          failures, cmp_count, cyc;

   ptc_pin_change i_ptc_pin_change (.i_core_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_porta(pa_w), .i_portb(pb_w),
      .i_portc(pc_w), .i_porte_pin3(pe_w), .o_irq(irq), .o_change_summary(summ));
   ptc_pin_model i_ptc_pin_model (.i_core_clk(clk), .o_porta(pa_w), .o_portb(pb_w),
      .o_portc(pc_w), .o_porte_pin3(pe_w));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 50 ns period.
   always #25 clk = ~clk;

   // Cuts a hang short after far more cycles than the tests need.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Byte address of a port register from its port and offset.
   function automatic logic [7:0] pa(input int p, input int o);
      return 8'((int'(IDX_PORT_BASE) + p * PORT_STRIDE + o) * 4);
   endfunction : pa

   // Write: address and data offered together, each released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit aw, w;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
   endtask : wr

   // Read: address held until taken, data taken with rvalid.
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask : rd

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      rd(a);
      chk(n, e, d);
   endtask : rdc

   // Drives a port and lets the edge pass the synchroniser.
   task automatic pin(input int p, input logic [7:0] v);
      i_ptc_pin_model.drive(p, v);
      repeat (8) @(posedge clk);
   endtask : pin

   ////////////////////////////////////////////////////////////////////////////////
   // reset values, unmapped access refused.
   task automatic test_reset();
      rdc(pa(3, OFS_FALL), 32'h0, "e_fall");
      rdc(pa(3, OFS_FLAG), 32'h0, "e_flag");
      rdc(pa(2, OFS_RISE), 32'h0, "c_rise");
      rd(8'hFC);
      chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("rd_unmapped_data", 32'h0, d);
      wr(8'hFC, 32'h1);
      chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test reset done");
   endtask : test_reset

   // port E pin edges and flag.
   task automatic test_porte();
      wr(pa(3, OFS_FALL), 32'hFF);
      rdc(pa(3, OFS_FALL), 32'h08, "e_fall_rb");
      pin(3, 8'hFF);
      rdc(pa(3, OFS_FLAG), 32'h0, "e_rise_off");
      pin(3, 8'h00);
      rdc(pa(3, OFS_FLAG), 32'h08, "e_fall_hit");
      chk("summary_out", 32'h1, {31'h0, summ});
      wr(pa(3, OFS_FLAG), 32'hF7);
      rdc(pa(3, OFS_FLAG), 32'h0, "e_flag_clr");
      wr(pa(3, OFS_FALL), 32'h0);
      wr(pa(3, OFS_RISE), 32'h08);
      pin(3, 8'hFF);
      rdc(pa(3, OFS_FLAG), 32'h08, "e_rise_hit");
      wr(pa(3, OFS_FLAG), 32'h0);
      wr(pa(3, OFS_RISE), 32'h0);
      pin(3, 8'h00);
      rdc(pa(3, OFS_FLAG), 32'h0, "e_both_off");
      $display("test porte done");
   endtask : test_porte

   // reset-pin and low-voltage bits block pin 3.
   task automatic test_block();
      wr(pa(3, OFS_FALL), 32'h08);
      for (int k = 0; k < 3; k++) begin
         wr({IDX_PINCFG, 2'b00}, 32'(k == 2 ? 0 : 1 << k));
         pin(3, 8'hFF);
         pin(3, 8'h00);
         rdc(pa(3, OFS_FLAG), (k == 2) ? 32'h08 : 32'h0, "e_blocked");
      end
      wr(pa(3, OFS_FLAG), 32'h0);
      wr(pa(3, OFS_FALL), 32'h0);
      $display("test block done");
   endtask : test_block

   // ports A, B, C on both edges.
   task automatic test_ports();
      for (int p = 0; p < 3; p++) begin
         wr(pa(p, OFS_RISE), 32'hFF);
         pin(p, 8'hFF);
         rdc(pa(p, OFS_FLAG), 32'(PORT_IMPL[p]), "rise_flags");
         wr(pa(p, OFS_FLAG), 32'h0);
         wr(pa(p, OFS_RISE), 32'h0);
         wr(pa(p, OFS_FALL), 32'hFF);
         pin(p, 8'h00);
         rdc(pa(p, OFS_FLAG), 32'(PORT_IMPL[p]), "fall_flags");
         wr(pa(p, OFS_FLAG), 32'h0);
         wr(pa(p, OFS_FALL), 32'h0);
      end
      $display("test ports done");
   endtask : test_ports

   // edge meeting a flag clear, then an edge held while frozen.
   task automatic test_setwins();
      wr(pa(1, OFS_RISE), 32'h04);
      i_ptc_pin_model.drive(1, 8'h04);
      @(posedge clk);
      wr(pa(1, OFS_FLAG), 32'h0);
      rdc(pa(1, OFS_FLAG), 32'h04, "b_set_wins");
      pin(1, 8'h00);
      wr(pa(1, OFS_FLAG), 32'h0);
      clk_en <= 1'b0;
      pin(1, 8'h04);
      chk("frozen_summary", 32'h0, {31'h0, summ});
      clk_en <= 1'b1;
      repeat (8) @(posedge clk);
      chk("thawed_summary", 32'h1, {31'h0, summ});
      wr(pa(1, OFS_RISE), 32'h0);
      wr(pa(1, OFS_FLAG), 32'h0);
      $display("test setwins done");
   endtask : test_setwins

   task automatic test_irq();
      wr(pa(0, OFS_RISE), 32'h01);
      wr({IDX_GCTRL, 2'b00}, 32'hC0);
      wr({IDX_PERIPHERAL_IRQ_ENABLE_0, 2'b00}, 32'h10);
      wr({IDX_IMASK, 2'b00}, 32'h1);
      pin(0, 8'h01);
      chk("irq_on", 32'h1, {31'h0, irq});
      rdc({IDX_ISTAT, 2'b00}, 32'h1, "status_set");
      wr({IDX_GCTRL, 2'b00}, 32'h40);
      repeat (3) @(posedge clk);
      chk("irq_global_off", 32'h0, {31'h0, irq});
      wr({IDX_GCTRL, 2'b00}, 32'hC0);
      wr({IDX_IMASK, 2'b00}, 32'h0);
      repeat (3) @(posedge clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr({IDX_IMASK, 2'b00}, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq_unmasked", 32'h1, {31'h0, irq});
      wr({IDX_ISTAT, 2'b00}, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      wr(pa(0, OFS_FLAG), 32'h0);
      rdc({IDX_SUMMARY, 2'b00}, 32'h0, "summary_reg");
      chk("summary_low", 32'h0, {31'h0, summ});
      $display("test irq done");
   endtask : test_irq

   task automatic test_rerst();
      wr(pa(0, OFS_RISE), 32'h5A);
      wr(pa(1, OFS_FLAG), 32'hFF);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdc(pa(0, OFS_RISE), 32'h0, "a_rise_rst");
      rdc(pa(1, OFS_FLAG), 32'h0, "b_flag_rst");
      chk("summary_rst", 32'h0, {31'h0, summ});
      $display("test rerst done");
   endtask : test_rerst

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////
   // Reset for eight cycles, then the scenarios in order.
   initial begin
      clk = 0;
      rst = 1;
      clk_en = 1;
      bready = 1;
      rready = 1;
      awvalid = 0;
      wvalid = 0;
      arvalid = 0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      test_reset();
      test_porte();
      test_block();
      test_ports();
      test_setwins();
      test_irq();
      test_rerst();
      final_report();
   end
endmodule : tb
`default_nettype wire
